// ===== core/asp_core.sv
// audio serial port: registers, companding, word counter, serial link
`timescale 1ns/1ps
`default_nettype none
module asp_core
    import asp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] xaddr,
    input wire logic xwr,
    input wire logic xrd,
    input wire logic [7:0] xwdata,
    output logic [7:0] xrdata,
    input wire logic link_sck,
    output logic sck_out,
    output logic sck_oe_n,
    input wire logic ws_in,
    output logic ws_out,
    output logic ws_oe_n,
    input wire logic sd_in,
    output logic sd_out,
    input wire logic usb_sof,
    input wire logic timer_one_compare_zero,
    input wire logic trigger_input_pin
);
    function automatic logic [15:0] ulaw_expand(input logic [7:0] b);
        logic [7:0] u;
        logic [15:0] t;
        u = ~b;
        t = (16'({u[3:0], 3'h0}) + ULAW_BIAS) << u[6:4];
        t = t - ULAW_BIAS;
        return u[7] ? 16'(-t) : t;
    endfunction

    function automatic logic [7:0] ulaw_compress(input logic [15:0] x);
        logic [15:0] m;
        logic [2:0] e;
        logic [3:0] q;
        m = x[15] ? 16'(-x) : x;
        if (m > ULAW_CLIP) begin
            m = ULAW_CLIP;
        end
        m = m + ULAW_BIAS;
        e = 3'h0;
        for (int i = 8; i < 15; i++) begin
            if (m[i]) begin
                e = 3'(i - 7);
            end
        end
        // widened so exponents above four do not wrap the shift
        q = 4'(m >> (4'(e) + 4'h3));
        return ~{x[15], e, q};
    endfunction

    asp_cfg_a_t cfg_a_ff;
    asp_cfg_b_t cfg_b_ff;
    logic [7:0] dat_lo_ff, dat_hi_ff, cap_lo_ff, xrdata_ff;
    logic [1:0] cap_hi_ff;
    logic [9:0] captured_word_count_ff, nxt_captured_word_count;
    logic [15:0] tx_hold_ff;
    logic tx_tgl_ff;
    logic wr_hi, wr_cap, cap_evt, hw_trig, ws_step;
    logic ws_s1_ff, ws_s2_ff, ws_s3_ff;
    logic pin_s1_ff, pin_s2_ff, pin_s3_ff;
    logic rx_s1_ff, rx_s2_ff, rx_s3_ff;
    logic [7:0] sck_div_ff;
    logic sck_gen_ff;
    // link side
    logic [15:0] rx_word_ff, rx_sh_ff, nxt_rx_sh, tx_buf_ff, tx_last_ff;
    logic [15:0] tx_sh_ff;
    logic rx_tgl_ff, ws_prev_ff, ws_chg_ff, ws_gen_ff, ws_cur;
    logic [4:0] rcnt_ff, tcnt_ff;
    logic [5:0] mcnt_ff;
    logic lrst1_ff, lrst_ff;
    logic tt1_ff, tt2_ff, tx_seen_ff;
    logic [7:0] lcfg1_ff, lcfg_ff;
    logic [4:0] lw1_ff, lw_ff;
    asp_cfg_a_t lcfg;

    assign wr_hi = xwr && (xaddr == DAT_HI_ADDR);
    assign wr_cap = xwr && (xaddr == CAPTURED_WORD_COUNT_ADDR);

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_a_ff <= CFG_A_RST;
            cfg_b_ff <= CFG_B_RST;
        end else if (xwr && xaddr == CFG_A_ADDR) begin
            cfg_a_ff <= xwdata;
        end else if (xwr && xaddr == CFG_B_ADDR) begin
            cfg_b_ff <= xwdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dat_lo_ff <= 8'h00;
            dat_hi_ff <= 8'h00;
        end else if (rx_s2_ff != rx_s3_ff && cfg_a_ff.port_enable_bit) begin
            if (cfg_a_ff.companding_compress_en) begin
                dat_hi_ff <= ulaw_compress(rx_word_ff);
            end else begin
                {dat_hi_ff, dat_lo_ff} <= rx_word_ff;
            end
        end else if (xwr && xaddr == DAT_LO_ADDR) begin
            dat_lo_ff <= xwdata;
        end else if (wr_hi && !cfg_a_ff.port_enable_bit
                     && cfg_a_ff.companding_expand_en
                     && !cfg_a_ff.companding_compress_en) begin
            {dat_hi_ff, dat_lo_ff} <= ulaw_expand(xwdata);
        end else if (wr_hi && !cfg_a_ff.port_enable_bit
                     && cfg_a_ff.companding_compress_en
                     && !cfg_a_ff.companding_expand_en) begin
            dat_hi_ff <= ulaw_compress({xwdata, dat_lo_ff});
        end else if (wr_hi) begin
            dat_hi_ff <= xwdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_hold_ff <= 16'h0000;
            tx_tgl_ff <= 1'b0;
        end else if (wr_hi && cfg_a_ff.port_enable_bit) begin
            tx_hold_ff <= cfg_a_ff.companding_expand_en
                ? ulaw_expand(xwdata) : {xwdata, dat_lo_ff};
            tx_tgl_ff <= ~tx_tgl_ff;
        end
    end

    // select line, trigger pin and receive event synchronisers
    always_ff @(posedge clk) begin
        if (rst) begin
            {ws_s1_ff, ws_s2_ff, ws_s3_ff} <= 3'h0;
            {pin_s1_ff, pin_s2_ff, pin_s3_ff} <= 3'h0;
            {rx_s1_ff, rx_s2_ff, rx_s3_ff} <= 3'h0;
        end else begin
            {ws_s1_ff, ws_s2_ff, ws_s3_ff} <= {ws_cur, ws_s1_ff, ws_s2_ff};
            {pin_s1_ff, pin_s2_ff, pin_s3_ff} <=
                {trigger_input_pin, pin_s1_ff, pin_s2_ff};
            {rx_s1_ff, rx_s2_ff, rx_s3_ff} <= {rx_tgl_ff, rx_s1_ff, rx_s2_ff};
        end
    end

    assign ws_step = ws_s2_ff != ws_s3_ff;

    always_comb begin
        case (cfg_b_ff.count_trigger_select)
            TRIG_NONE: hw_trig = 1'b0;
            TRIG_SOF: hw_trig = usb_sof;
            TRIG_PIN: hw_trig = pin_s2_ff != pin_s3_ff;
            TRIG_TMR: hw_trig = timer_one_compare_zero;
            default: hw_trig = 1'b0;
        endcase
    end

    assign cap_evt = hw_trig || wr_cap;

    // counting; a step in the clear cycle survives
    always_comb begin
        nxt_captured_word_count = cap_evt ? 10'h000 : captured_word_count_ff;
        if (ws_step && nxt_captured_word_count != CAPTURED_WORD_COUNT_MAX) begin
            nxt_captured_word_count = nxt_captured_word_count + 10'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            captured_word_count_ff <= 10'h000;
            cap_lo_ff <= 8'h00;
            cap_hi_ff <= 2'h0;
        end else begin
            captured_word_count_ff <= nxt_captured_word_count;
            if (cap_evt) begin
                {cap_hi_ff, cap_lo_ff} <= captured_word_count_ff;
            end
        end
    end

    // register reads, unmapped in range reads zero
    always_ff @(posedge clk) begin
        if (rst) begin
            xrdata_ff <= 8'h00;
        end else if (xrd) begin
            case (xaddr)
                CFG_A_ADDR: xrdata_ff <= cfg_a_ff;
                CFG_B_ADDR: xrdata_ff <= cfg_b_ff;
                DAT_LO_ADDR: xrdata_ff <= dat_lo_ff;
                DAT_HI_ADDR: xrdata_ff <= dat_hi_ff;
                CAPTURED_WORD_COUNT_ADDR: xrdata_ff <= cap_lo_ff;
                STAT_ADDR: xrdata_ff <= {5'h00, ws_s3_ff, cap_hi_ff};
                default: xrdata_ff <= 8'h00;
            endcase
        end
    end

    assign xrdata = xrdata_ff;

    // master bit clock; fixed divider stands in for the fractional one
    always_ff @(posedge clk) begin
        if (rst || !cfg_a_ff.master || !cfg_a_ff.port_enable_bit) begin
            sck_div_ff <= 8'h00;
            sck_gen_ff <= 1'b0;
        end else if (sck_div_ff == SCK_HALF) begin
            sck_div_ff <= 8'h00;
            sck_gen_ff <= ~sck_gen_ff;
        end else begin
            sck_div_ff <= sck_div_ff + 8'h01;
        end
    end

    assign sck_out = sck_gen_ff;
    assign sck_oe_n = ~cfg_a_ff.master;
    assign ws_out = ws_gen_ff;
    assign ws_oe_n = ~cfg_a_ff.master;

    // link domain: reset, transmit toggle and quasi-static config, set before enable
    always_ff @(posedge link_sck) begin
        lrst1_ff <= rst;
        lrst_ff <= lrst1_ff;
        lcfg1_ff <= cfg_a_ff;
        lcfg_ff <= lcfg1_ff;
        lw1_ff <= cfg_b_ff.words;
        lw_ff <= lw1_ff;
        tt1_ff <= tx_tgl_ff;
        tt2_ff <= tt1_ff;
    end

    assign lcfg = lcfg_ff;
    assign ws_cur = lcfg.master ? ws_gen_ff : ws_in;

    // receive, msb first into top 16 bits
    always_comb begin
        nxt_rx_sh = rx_sh_ff;
        if (rcnt_ff < SAMPLE_LAST) begin
            nxt_rx_sh[4'(15 - rcnt_ff)] = sd_in;
        end
    end

    always_ff @(posedge link_sck) begin
        if (lrst_ff) begin
            ws_prev_ff <= 1'b0;
            ws_chg_ff <= 1'b0;
            rcnt_ff <= SAMPLE_LAST;
            rx_sh_ff <= 16'h0000;
            rx_word_ff <= 16'h0000;
            rx_tgl_ff <= 1'b0;
        end else begin
            ws_prev_ff <= ws_cur;
            ws_chg_ff <= ws_cur != ws_prev_ff;
            if (ws_cur != ws_prev_ff) begin
                rcnt_ff <= 5'h00;
                rx_sh_ff <= 16'h0000;
                if (!(lcfg.receive_single_channel && ws_prev_ff)
                    && lcfg.port_enable_bit) begin
                    rx_word_ff <= nxt_rx_sh;
                    rx_tgl_ff <= ~rx_tgl_ff;
                end
            end else begin
                rx_sh_ff <= nxt_rx_sh;
                if (rcnt_ff < SAMPLE_LAST) begin
                    rcnt_ff <= rcnt_ff + 5'h01;
                end
            end
        end
    end

    // transmit buffer takes each handed-off word
    always_ff @(posedge link_sck) begin
        if (lrst_ff) begin
            tx_seen_ff <= 1'b0;
            tx_buf_ff <= 16'h0000;
        end else if (tt2_ff != tx_seen_ff) begin
            tx_seen_ff <= tt2_ff;
            tx_buf_ff <= tx_hold_ff;
        end
    end

    // master select, toggles every words+1 bits
    always_ff @(negedge link_sck) begin
        if (lrst_ff || !lcfg.master || !lcfg.port_enable_bit) begin
            mcnt_ff <= 6'h00;
            ws_gen_ff <= 1'b0;
        end else if (mcnt_ff == {1'b0, lw_ff}) begin
            mcnt_ff <= 6'h00;
            ws_gen_ff <= ~ws_gen_ff;
        end else begin
            mcnt_ff <= mcnt_ff + 6'h01;
        end
    end

    // shift out; zeros fill past 16 bits
    always_ff @(negedge link_sck) begin
        if (lrst_ff) begin
            tx_sh_ff <= 16'h0000;
            tx_last_ff <= 16'h0000;
            tcnt_ff <= SAMPLE_LAST;
        end else if (ws_chg_ff) begin
            tcnt_ff <= 5'h00;
            if (lcfg.transmit_single_channel && ws_prev_ff) begin
                tx_sh_ff <= tx_last_ff;
            end else begin
                tx_sh_ff <= tx_buf_ff;
                tx_last_ff <= tx_buf_ff;
            end
        end else begin
            tx_sh_ff <= {tx_sh_ff[14:0], 1'b0};
            if (tcnt_ff < SAMPLE_LAST) begin
                tcnt_ff <= tcnt_ff + 5'h01;
            end
        end
    end

    assign sd_out = tx_sh_ff[15] && lcfg.port_enable_bit;

    sequence exp_wr_s;
        wr_hi && !cfg_a_ff.port_enable_bit
        && cfg_a_ff.companding_expand_en
        && !cfg_a_ff.companding_compress_en
        && !(rx_s2_ff != rx_s3_ff);
    endsequence

    sequence cmp_wr_s;
        wr_hi && !cfg_a_ff.port_enable_bit
        && cfg_a_ff.companding_compress_en
        && !cfg_a_ff.companding_expand_en;
    endsequence

    expand_one_clk_a: assert property (@(posedge clk) disable iff (rst)
        exp_wr_s |=> {dat_hi_ff, dat_lo_ff} == ulaw_expand($past(xwdata)))
        else $error("standalone expansion result wrong");

    compress_one_clk_a: assert property (@(posedge clk) disable iff (rst)
        cmp_wr_s ##0 !(rx_s2_ff != rx_s3_ff)
        |=> dat_hi_ff == ulaw_compress({$past(xwdata), $past(dat_lo_ff)}))
        else $error("standalone compression result wrong");

    count_capture_a: assert property (@(posedge clk) disable iff (rst)
        cap_evt |=> {cap_hi_ff, cap_lo_ff} == $past(captured_word_count_ff)
        && captured_word_count_ff <= 10'h001)
        else $error("capture did not copy and clear");

    count_saturate_a: assert property (@(posedge clk) disable iff (rst)
        captured_word_count_ff == CAPTURED_WORD_COUNT_MAX && !cap_evt |=> captured_word_count_ff == CAPTURED_WORD_COUNT_MAX)
        else $error("word counter wrapped");

    count_step_a: assert property (@(posedge clk) disable iff (rst)
        ws_step && !cap_evt && captured_word_count_ff != CAPTURED_WORD_COUNT_MAX
        |=> captured_word_count_ff == $past(captured_word_count_ff) + 10'h001)
        else $error("select transition not counted");

    no_hw_trig_a: assert property (@(posedge clk) disable iff (rst)
        cfg_b_ff.count_trigger_select == TRIG_NONE && !wr_cap
        |=> $stable({cap_hi_ff, cap_lo_ff}))
        else $error("capture without software write");

    pin_drive_a: assert property (@(posedge clk) disable iff (rst)
        sck_oe_n == !cfg_a_ff.master && ws_oe_n == !cfg_a_ff.master)
        else $error("pin drive does not follow master bit");

    tx_zero_pad_a: assert property (@(negedge link_sck)
        disable iff (lrst_ff)
        tcnt_ff == SAMPLE_LAST && !ws_chg_ff |=> !sd_out)
        else $error("bits past sixteen not zero");

    rx_mono_drop_a: assert property (@(posedge link_sck)
        disable iff (lrst_ff)
        ws_cur != ws_prev_ff && ws_prev_ff
        && lcfg.receive_single_channel |=> $stable(rx_tgl_ff))
        else $error("right word delivered in mono");

    ws_period_a: assert property (@(negedge link_sck)
        disable iff (lrst_ff || !lcfg.master || !lcfg.port_enable_bit)
        mcnt_ff == {1'b0, lw_ff} |=> $changed(ws_gen_ff) && mcnt_ff == 6'h00)
        else $error("select period wrong");
endmodule
`default_nettype wire

// ===== shared/asp_pkg.sv
// constants, register map and field types of the audio serial port
package asp_pkg;
    localparam logic [15:0] CFG_A_ADDR = 16'hDF40;
    localparam logic [15:0] CFG_B_ADDR = 16'hDF41;
    localparam logic [15:0] DAT_LO_ADDR = 16'hDF42;
    localparam logic [15:0] DAT_HI_ADDR = 16'hDF43;
    localparam logic [15:0] CAPTURED_WORD_COUNT_ADDR = 16'hDF44;
    localparam logic [15:0] STAT_ADDR = 16'hDF45;
    localparam logic [15:0] LAST_ADDR = 16'hDF48;
    localparam logic [7:0] CFG_A_RST = 8'h00;
    localparam logic [7:0] CFG_B_RST = 8'h78;
    localparam logic [4:0] WORDS_RST = 5'h0F;
    localparam int SAMPLE_BITS = 16;
    localparam logic [4:0] SAMPLE_LAST = 5'h10;
    localparam logic [9:0] CAPTURED_WORD_COUNT_MAX = 10'h3FF;
    localparam logic [15:0] ULAW_BIAS = 16'h0084;
    localparam logic [15:0] ULAW_CLIP = 16'h7F7B;
    localparam real CLK_NS = 5.0;
    localparam real SCK_HALF_NS = 60.0;
    localparam int SCK_HALF_CYC = int'(SCK_HALF_NS / CLK_NS);
    localparam logic [7:0] SCK_HALF = 8'(SCK_HALF_CYC - 1);

    typedef enum logic [1:0] {
        TRIG_NONE = 2'h0,
        TRIG_SOF = 2'h1,
        TRIG_PIN = 2'h2,
        TRIG_TMR = 2'h3
    } asp_trig_t;

    typedef struct packed {
        logic transmit_irq_enable;
        logic receive_irq_enable;
        logic companding_expand_en;
        logic companding_compress_en;
        logic transmit_single_channel;
        logic receive_single_channel;
        logic master;
        logic port_enable_bit;
    } asp_cfg_a_t;

    typedef struct packed {
        logic [4:0] words;
        asp_trig_t count_trigger_select;
        logic pin_loc;
    } asp_cfg_b_t;
endpackage

// ===== bench/asp_codec_model.sv
// behavioural external audio master: clock, select, data, listener
`timescale 1ns/1ps
`default_nettype none
module asp_codec_model (
    input wire logic sck_line,
    input wire logic ws_line,
    input wire logic tx_line,
    output logic sck,
    output logic ws,
    output logic sd
);
    logic [39:0] sh = '0;
    logic [39:0] last_data = '0;
    logic last_ch = 1'b0;
    logic pend = 1'b0;
    logic ws_q = 1'b1;
    int n_bits = 0;
    int last_n = 0;
    int n_words = 0;
    initial begin
        sck = 1'b0;
        ws = 1'b1;
        sd = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) begin
            #6 sck = 1'b1;
            #6 sck = 1'b0;
        end
    endtask
    // select sets length, msb after one bit
    task automatic word(input logic ch, input logic [39:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            ws = ch;
            sd = (i == 0) ? pend : d[n - i];
            #6 sck = 1'b1;
            #6 sck = 1'b0;
        end
        pend = d[0];
        // released line, never the last value
        sd = ~sd;
    endtask
    // word closes with the bit at the select change
    always @(posedge sck_line) begin
        if (ws_line !== ws_q) begin
            last_data <= {sh[38:0], tx_line};
            last_ch <= ws_q;
            last_n <= n_bits + 1;
            n_words <= n_words + 1;
            sh <= '0;
            n_bits <= 0;
        end else begin
            sh <= {sh[38:0], tx_line};
            n_bits <= n_bits + 1;
        end
        ws_q <= ws_line;
    end
endmodule
`default_nettype wire

// ===== bench/asp_core_tb_top.sv
// self-checking bench for the audio serial port core
`timescale 1ns/1ps
`default_nettype none
module asp_core_tb_top
    import asp_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] xaddr = '0;
    logic xwr = 1'b0;
    logic xrd = 1'b0;
    logic [7:0] xwdata = '0;
    logic usb_sof = 1'b0;
    logic tmr_cmp = 1'b0;
    logic trig_pin = 1'b0;
    logic [7:0] xrdata;
    logic sck_out, sck_oe_n, ws_out, ws_oe_n, sd_out;
    logic p_sck, p_ws, p_sd;
    logic [7:0] v;
    int n_errors = 0;
    int tests_run = 0;
    // pads resolve to whichever side drives them
    wire link_sck = sck_oe_n ? p_sck : sck_out;
    wire ws_line = ws_oe_n ? p_ws : ws_out;
    always #2.5 clk = ~clk;
    asp_core i_dut (.clk(clk), .rst(rst), .xaddr(xaddr), .xwr(xwr),
        .xrd(xrd), .xwdata(xwdata), .xrdata(xrdata), .link_sck(link_sck),
        .sck_out(sck_out), .sck_oe_n(sck_oe_n), .ws_in(ws_line),
        .ws_out(ws_out), .ws_oe_n(ws_oe_n), .sd_in(p_sd), .sd_out(sd_out),
        .usb_sof(usb_sof), .timer_one_compare_zero(tmr_cmp),
        .trigger_input_pin(trig_pin));
    asp_codec_model i_codec (.sck_line(link_sck), .ws_line(ws_line),
        .tx_line(sd_out), .sck(p_sck), .ws(p_ws), .sd(p_sd));
    task automatic close_out();
        $display("compares %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        tests_run++;
        if (got !== want) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        xaddr <= a;
        xwdata <= d;
        xwr <= 1'b1;
        @(posedge clk);
        xwr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        xaddr <= a;
        xrd <= 1'b1;
        @(posedge clk);
        xrd <= 1'b0;
        @(posedge clk);
        d = xrdata;
    endtask
    task automatic r16(output logic [15:0] d);
        rd(DAT_LO_ADDR, d[7:0]);
        rd(DAT_HI_ADDR, d[15:8]);
    endtask
    task automatic t_regs();
        rd(CFG_A_ADDR, v);
        chk(32'(v), 32'h00);
        rd(CFG_B_ADDR, v);
        chk(32'(v), 32'h78);
        chk(32'({sck_oe_n, ws_oe_n}), 32'h3);
        wr(CFG_A_ADDR, 8'hC0);
        wr(16'hDF47, 8'h55);
        rd(CFG_A_ADDR, v);
        chk(32'(v), 32'hC0);
        rd(16'hDF47, v);
        chk(32'(v), 32'h00);
        $display("test regs done");
    endtask
    task automatic t_law();
        logic [7:0] cfg [5] = '{8'h20, 8'h20, 8'h10, 8'h10, 8'h10};
        logic [15:0] din [5] = '{16'h8000, 16'h0000, 16'h7FFF,
            16'h8000, 16'h0000};
        logic [15:0] want [5] = '{16'h7D7C, 16'h8284, 16'h0080,
            16'h0000, 16'h00FF};
        logic [15:0] d;
        for (int i = 0; i < 5; i++) begin
            wr(CFG_A_ADDR, cfg[i]);
            wr(DAT_LO_ADDR, din[i][7:0]);
            wr(DAT_HI_ADDR, din[i][15:8]);
            r16(d);
            if (cfg[i][5]) begin
                chk(32'(d), 32'(want[i]));
            end else begin
                chk(32'(d[15:8]), 32'(want[i]));
            end
        end
        $display("test compander done");
    endtask
    task automatic pulse(input int s);
        @(posedge clk);
        if (s == 1) usb_sof <= 1'b1;
        if (s == 3) tmr_cmp <= 1'b1;
        if (s == 2) trig_pin <= ~trig_pin;
        @(posedge clk);
        usb_sof <= 1'b0;
        tmr_cmp <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task automatic burst(input int n);
        repeat (n) i_codec.word(~p_ws, 40'h0, 2);
        repeat (10) @(posedge clk);
    endtask
    task automatic t_trig();
        wr(CFG_A_ADDR, 8'h01);
        for (int c = 0; c < 4; c++) begin
            wr(CFG_B_ADDR, 8'h78 | 8'(c << 1));
            wr(CAPTURED_WORD_COUNT_ADDR, 8'h00);
            wr(CAPTURED_WORD_COUNT_ADDR, 8'h00);
            burst(c + 3);
            for (int s = 1; s < 4; s++) if (s != c) pulse(s);
            rd(CAPTURED_WORD_COUNT_ADDR, v);
            chk(32'(v), 32'h0);
            pulse(c);
            rd(CAPTURED_WORD_COUNT_ADDR, v);
            chk(32'(v), (c == 0) ? 32'h0 : 32'(c + 3));
        end
        burst(4);
        wr(CAPTURED_WORD_COUNT_ADDR, 8'h5A);
        rd(CAPTURED_WORD_COUNT_ADDR, v);
        chk(32'(v), 32'h4);
        burst(1030);
        wr(CAPTURED_WORD_COUNT_ADDR, 8'h00);
        rd(CAPTURED_WORD_COUNT_ADDR, v);
        chk(32'(v), 32'hFF);
        rd(STAT_ADDR, v);
        chk(32'(v & 8'h03), 32'h3);
        $display("test counter done");
    endtask
    task automatic t_slave();
        logic [15:0] d;
        wr(CFG_B_ADDR, 8'h18);
        wr(CFG_A_ADDR, 8'h09);
        wr(DAT_LO_ADDR, 8'hA5);
        wr(DAT_HI_ADDR, 8'hC3);
        // clocks let the new word and config reach the link first
        i_codec.word(1'b1, 40'h0, 20);
        i_codec.word(1'b0, 40'hABCDE, 20);
        i_codec.word(1'b1, 40'h13579, 20);
        i_codec.word(1'b0, 40'h0, 20);
        repeat (10) @(posedge clk);
        r16(d);
        chk(32'(d), 32'h1357);
        chk(i_codec.last_data[31:0], 32'hC3A50);
        wr(CFG_A_ADDR, 8'h0D);
        i_codec.word(1'b1, 40'h0, 20);
        i_codec.word(1'b0, 40'h2468A, 20);
        i_codec.word(1'b1, 40'hFEDCB, 20);
        i_codec.word(1'b0, 40'h0, 20);
        repeat (10) @(posedge clk);
        r16(d);
        chk(32'(d), 32'h2468);
        wr(CFG_A_ADDR, 8'h3D);
        wr(DAT_HI_ADDR, 8'h80);
        i_codec.word(1'b1, 40'h0, 20);
        i_codec.word(1'b0, 40'h2468A, 20);
        i_codec.word(1'b1, 40'hFEDCB, 20);
        i_codec.word(1'b0, 40'h0, 20);
        repeat (10) @(posedge clk);
        rd(DAT_HI_ADDR, v);
        chk(32'(v), 32'h9D);
        chk(i_codec.last_data[31:0], 32'h7D7C0);
        $display("test slave done");
    endtask
    task automatic t_master();
        int k;
        wr(CFG_A_ADDR, 8'h00);
        wr(CFG_B_ADDR, 8'h98);
        wr(CFG_A_ADDR, 8'h0B);
        wr(DAT_LO_ADDR, 8'h34);
        wr(DAT_HI_ADDR, 8'h12);
        k = i_codec.n_words + 4;
        for (int i = 0; i < 4000 && i_codec.n_words < k; i++) begin
            @(posedge clk);
        end
        if (i_codec.n_words < k) begin
            n_errors++;
            close_out();
        end
        chk(32'({sck_oe_n, ws_oe_n}), 32'h0);
        chk(i_codec.last_data[31:0], 32'h12340);
        chk(32'(i_codec.last_n), 32'd20);
        $display("test master done");
    endtask
    initial begin
        fork
            i_codec.tick(4);
            repeat (12) @(posedge clk);
        join
        rst <= 1'b0;
        t_regs();
        t_law();
        t_trig();
        t_slave();
        t_master();
        close_out();
    end
endmodule
`default_nettype wire
